//--- inc/psc_pkg.sv
// constants and types for the power-up settings command decoder
package psc_pkg;
    localparam int REPORT_BYTES = 64;
    localparam logic [7:0] CMD_NVRAM = 8'h60;
    localparam logic [7:0] SUB_CHIP  = 8'h20;
    localparam logic [7:0] ST_OK     = 8'h00;
    localparam logic [7:0] ST_BLOCK  = 8'hfb;
    localparam logic [7:0] ST_UNSUP  = 8'hf8;
    localparam logic [7:0] ACC_OPEN  = 8'h00;
    localparam logic [7:0] ACC_PASS  = 8'h40;
    localparam logic [7:0] ACC_LOCK  = 8'h80;
    localparam logic [7:0] DES_GPIO  = 8'h00;
    localparam logic [7:0] DES_CS    = 8'h01;
    localparam logic [7:0] DES_FUNC  = 8'h02;
    localparam logic [5:0] IDX_CMD   = 6'h00;
    localparam logic [5:0] IDX_SUB   = 6'h01;
    localparam logic [5:0] IDX_DES0  = 6'h04;
    localparam logic [5:0] IDX_DES8  = 6'h0c;
    localparam logic [5:0] IDX_VAL   = 6'h0d;
    localparam logic [5:0] IDX_DIR   = 6'h0f;
    localparam logic [5:0] IDX_DIR_HI = 6'h10;
    localparam logic [5:0] IDX_OPT   = 6'h11;
    localparam logic [5:0] IDX_ACC   = 6'h12;
    localparam logic [5:0] IDX_PW0   = 6'h13;
    localparam logic [5:0] IDX_PW7   = 6'h1a;
    localparam logic [5:0] IDX_LAST  = 6'h3f;
    localparam int OPT_WAKE = 4;
    localparam int OPT_INT_HI = 3;
    localparam int OPT_INT_LO = 1;
    localparam int OPT_REL = 0;
    localparam logic [2:0] INT_MAX = 3'h4;
    // nonvolatile defaults after first power-up; plain values
    localparam logic [17:0] RST_DES   = 18'h00000;
    localparam logic [7:0]  RST_VAL   = 8'h00;
    localparam logic [8:0]  RST_DIR   = 9'h1ff;
    localparam logic [7:0]  RST_OPT   = 8'h00;
    localparam logic [7:0]  RST_ACC   = 8'h00;
    localparam logic [63:0] RST_PW    = 64'h0;
    typedef enum logic [2:0] {
        PSC_IDLE = 3'b000,
        PSC_RECV = 3'b001,
        PSC_EXEC = 3'b011,
        PSC_RESP = 3'b010,
        PSC_LOAD = 3'b110
    } psc_state_t;
endpackage

//--- verilog/psc_resp.sv
// response byte serialiser: streams 64 bytes, three of them meaningful
module psc_resp (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       start,
    input  wire logic [7:0] b0,
    input  wire logic [7:0] b1,
    input  wire logic [7:0] b2,
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    output logic            rsp_last,
    output logic            busy
);
    logic [5:0] idx_r;
    logic [7:0] b0_r, b1_r, b2_r;
    wire  [7:0] sel_byte = (idx_r == 6'h00) ? b0_r :
                           (idx_r == 6'h01) ? b1_r :
                           (idx_r == 6'h02) ? b2_r : 8'h00;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy      <= 1'b0;
            idx_r     <= 6'h00;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
            rsp_last  <= 1'b0;
            b0_r      <= 8'h00;
            b1_r      <= 8'h00;
            b2_r      <= 8'h00;
        end else if (start && !busy) begin
            busy      <= 1'b1;
            idx_r     <= 6'h00;
            rsp_valid <= 1'b0;
            rsp_last  <= 1'b0;
            b0_r      <= b0;
            b1_r      <= b1;
            b2_r      <= b2;
        end else if (busy) begin
            rsp_valid <= 1'b1;
            rsp_data  <= sel_byte;
            rsp_last  <= (idx_r == psc_pkg::IDX_LAST);
            idx_r     <= idx_r + 6'h01;
            busy      <= (idx_r != psc_pkg::IDX_LAST);
        end else begin
            rsp_valid <= 1'b0;
            rsp_last  <= 1'b0;
        end
    end
endmodule

//--- verilog/psc_top.sv
// power-up chip settings command decoder with nonvolatile and working copies
// Operation
// - every command report gets one response
// - byte0 0x60, byte1 0x20 selects write
// - bytes 4-12 set pin designations
// - byte 13 default output levels, 14 ignored
// - byte 15 directions, byte 16 always sets ninth pin direction to 1
// - option bit 4 enables remote wake-up
// - option bits 3-1 interrupt counting mode
// - option bit 0 holds SPI bus
// - byte 18 access mode open/password/locked
// - bytes 19-26 new password characters
// - reset copies stored settings to working
// - response byte 0 echoes command code
// - locked or unmatched password returns 0xfb
// - success returns 0x00 and echoes 0x20
// - working settings writable despite protection
module psc_top (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_data,
    input  wire logic        cmd_last,
    input  wire logic        password_matched,
    input  wire logic        ram_wr_en,
    input  wire logic [17:0] ram_wr_des,
    input  wire logic [7:0]  ram_wr_val,
    input  wire logic [8:0]  ram_wr_dir,
    input  wire logic [7:0]  ram_wr_opt,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_last,
    output logic             nv_write_pulse,
    output logic [17:0]      nv_designation,
    output logic [7:0]       nv_access_mode,
    output logic [63:0]      nv_password,
    output logic [17:0]      work_designation,
    output logic [7:0]       work_out_level,
    output logic [8:0]       work_direction,
    output logic             work_remote_wake,
    output logic [2:0]       work_int_mode,
    output logic             work_bus_hold
);
    psc_pkg::psc_state_t state_r;
    logic [5:0]  idx_r;
    logic [7:0]  cmd_r, sub_r;
    // nine pins of two bits each; the ninth pin sits in [17:16]
    logic [17:0] st_des_r, nv_des_r;
    logic [7:0]  st_val_r, nv_val_r;
    logic [8:0]  st_dir_r, nv_dir_r;
    logic [7:0]  st_opt_r, nv_opt_r;
    logic [7:0]  st_acc_r, nv_acc_r;
    logic [63:0] st_pw_r, nv_pw_r;
    logic        rsp_start_r;
    logic [7:0]  rb0_r, rb1_r, rb2_r;
    logic        rsp_busy;

    // two-bit code per pin; larger codes are clamped to dedicated function
    function automatic logic [1:0] des_code(input logic [7:0] b, input logic ninth);
        if (b == psc_pkg::DES_GPIO)
            return 2'h0;
        else if (b == psc_pkg::DES_CS && !ninth)
            return 2'h1;
        else
            return 2'h2;
    endfunction

    wire take      = cmd_valid && cmd_ready;
    wire in_des    = idx_r >= psc_pkg::IDX_DES0 && idx_r <= psc_pkg::IDX_DES8;
    wire [3:0] pin = 4'(idx_r - psc_pkg::IDX_DES0);
    wire in_pw     = idx_r >= psc_pkg::IDX_PW0 && idx_r <= psc_pkg::IDX_PW7;
    wire [2:0] pwc = 3'(idx_r - psc_pkg::IDX_PW0);
    wire is_write  = cmd_r == psc_pkg::CMD_NVRAM && sub_r == psc_pkg::SUB_CHIP;
    wire locked    = nv_acc_r == psc_pkg::ACC_LOCK;
    wire pw_block  = nv_acc_r == psc_pkg::ACC_PASS && !password_matched;
    wire refuse    = locked || pw_block;
    wire pw_keep   = st_pw_r == 64'h0;
    wire [2:0] int_in = st_opt_r[psc_pkg::OPT_INT_HI:psc_pkg::OPT_INT_LO];

    psc_resp u_resp (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .start     (rsp_start_r),
        .b0        (rb0_r),
        .b1        (rb1_r),
        .b2        (rb2_r),
        .rsp_valid (rsp_valid),
        .rsp_data  (rsp_data),
        .rsp_last  (rsp_last),
        .busy      (rsp_busy)
    );

    // command reception and staging
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r  <= psc_pkg::PSC_LOAD;
            idx_r    <= 6'h00;
            cmd_r    <= 8'h00;
            sub_r    <= 8'h00;
            st_des_r <= psc_pkg::RST_DES;
            st_val_r <= psc_pkg::RST_VAL;
            st_dir_r <= psc_pkg::RST_DIR;
            st_opt_r <= psc_pkg::RST_OPT;
            st_acc_r <= psc_pkg::RST_ACC;
            st_pw_r  <= psc_pkg::RST_PW;
            cmd_ready <= 1'b0;
        end else begin
            unique case (state_r)
                psc_pkg::PSC_LOAD: begin
                    state_r   <= psc_pkg::PSC_IDLE;
                    cmd_ready <= 1'b1;
                end
                psc_pkg::PSC_IDLE, psc_pkg::PSC_RECV: begin
                    if (take) begin
                        state_r <= psc_pkg::PSC_RECV;
                        idx_r   <= idx_r + 6'h01;
                        if (idx_r == psc_pkg::IDX_CMD)
                            cmd_r <= cmd_data;
                        if (idx_r == psc_pkg::IDX_SUB)
                            sub_r <= cmd_data;
                        if (in_des)
                            st_des_r[2*pin +: 2] <= des_code(cmd_data, pin == 4'h8);
                        if (idx_r == psc_pkg::IDX_VAL)
                            st_val_r <= cmd_data;
                        if (idx_r == psc_pkg::IDX_DIR)
                            st_dir_r[7:0] <= cmd_data;
                        if (idx_r == psc_pkg::IDX_DIR_HI)
                            st_dir_r[8] <= 1'b1;
                        if (idx_r == psc_pkg::IDX_OPT)
                            st_opt_r <= {3'h0, cmd_data[4:0]};
                        if (idx_r == psc_pkg::IDX_ACC)
                            st_acc_r <= cmd_data;
                        if (in_pw)
                            st_pw_r[8*pwc +: 8] <= cmd_data;
                        if (cmd_last || idx_r == psc_pkg::IDX_LAST) begin
                            state_r   <= psc_pkg::PSC_EXEC;
                            cmd_ready <= 1'b0;
                        end
                    end
                end
                psc_pkg::PSC_EXEC: begin
                    state_r <= psc_pkg::PSC_RESP;
                end
                psc_pkg::PSC_RESP: begin
                    if (!rsp_busy && !rsp_start_r) begin
                        state_r   <= psc_pkg::PSC_IDLE;
                        idx_r     <= 6'h00;
                        st_pw_r   <= 64'h0;
                        cmd_ready <= 1'b1;
                    end
                end
                default: begin
                    state_r <= psc_pkg::PSC_LOAD;
                end
            endcase
        end
    end

    // decision, atomic commit and response bytes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rsp_start_r    <= 1'b0;
            rb0_r          <= 8'h00;
            rb1_r          <= 8'h00;
            rb2_r          <= 8'h00;
            nv_write_pulse <= 1'b0;
        end else begin
            rsp_start_r    <= 1'b0;
            nv_write_pulse <= 1'b0;
            if (state_r == psc_pkg::PSC_EXEC) begin
                rsp_start_r <= 1'b1;
                rb0_r       <= cmd_r;
                rb2_r       <= 8'h00;
                if (!is_write) begin
                    // other commands belong to sibling decoders; answer anyway
                    rb1_r <= psc_pkg::ST_UNSUP;
                end else if (refuse) begin
                    rb1_r <= psc_pkg::ST_BLOCK;
                end else begin
                    rb1_r          <= psc_pkg::ST_OK;
                    rb2_r          <= psc_pkg::SUB_CHIP;
                    nv_write_pulse <= 1'b1;
                end
            end
        end
    end

    // nonvolatile image: only written as one unit on accept
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            nv_des_r <= psc_pkg::RST_DES;
            nv_val_r <= psc_pkg::RST_VAL;
            nv_dir_r <= psc_pkg::RST_DIR;
            nv_opt_r <= psc_pkg::RST_OPT;
            nv_acc_r <= psc_pkg::RST_ACC;
            nv_pw_r  <= psc_pkg::RST_PW;
        end else if (state_r == psc_pkg::PSC_EXEC && is_write && !refuse) begin
            nv_des_r <= st_des_r;
            nv_val_r <= st_val_r;
            nv_dir_r <= st_dir_r;
            // reserved interrupt codes are stored as no counting
            nv_opt_r <= (int_in > psc_pkg::INT_MAX) ? {st_opt_r[7:4], 3'h0, st_opt_r[0]} : st_opt_r;
            nv_acc_r <= st_acc_r;
            if (!pw_keep)
                nv_pw_r <= st_pw_r;
        end
    end

    // working copy loaded from nonvolatile after reset, then ram writes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            work_designation <= psc_pkg::RST_DES;
            work_out_level   <= 8'h00;
            work_direction   <= 9'h000;
            work_remote_wake <= 1'b0;
            work_int_mode    <= 3'h0;
            work_bus_hold    <= 1'b0;
        end else if (state_r == psc_pkg::PSC_LOAD) begin
            work_designation <= nv_des_r;
            work_out_level   <= nv_val_r;
            work_direction   <= nv_dir_r;
            work_remote_wake <= nv_opt_r[psc_pkg::OPT_WAKE];
            work_int_mode    <= nv_opt_r[psc_pkg::OPT_INT_HI:psc_pkg::OPT_INT_LO];
            work_bus_hold    <= nv_opt_r[psc_pkg::OPT_REL];
        end else if (ram_wr_en) begin
            work_designation <= ram_wr_des;
            work_out_level   <= ram_wr_val;
            work_direction   <= ram_wr_dir;
            work_remote_wake <= ram_wr_opt[psc_pkg::OPT_WAKE];
            work_int_mode    <= ram_wr_opt[psc_pkg::OPT_INT_HI:psc_pkg::OPT_INT_LO];
            work_bus_hold    <= ram_wr_opt[psc_pkg::OPT_REL];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            nv_designation <= psc_pkg::RST_DES;
            nv_access_mode <= 8'h00;
            nv_password    <= 64'h0;
        end else begin
            nv_designation <= nv_des_r;
            nv_access_mode <= nv_acc_r;
            nv_password    <= nv_pw_r;
        end
    end
endmodule

//--- tb/psc_props.sv
// assertion checker for the power-up settings command decoder
module psc_props (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_data,
    input wire logic        cmd_last,
    input wire logic        password_matched,
    input wire logic        ram_wr_en,
    input wire logic [17:0] ram_wr_des,
    input wire logic [7:0]  ram_wr_val,
    input wire logic [8:0]  ram_wr_dir,
    input wire logic [7:0]  ram_wr_opt,
    input wire logic        cmd_ready,
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_data,
    input wire logic        rsp_last,
    input wire logic        nv_write_pulse,
    input wire logic [17:0] nv_designation,
    input wire logic [7:0]  nv_access_mode,
    input wire logic [63:0] nv_password,
    input wire logic [17:0] work_designation,
    input wire logic [7:0]  work_out_level,
    input wire logic [8:0]  work_direction,
    input wire logic        work_remote_wake,
    input wire logic [2:0]  work_int_mode,
    input wire logic        work_bus_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [6:0] n_rsp_r;
    logic       took_r;
    logic [7:0] cmd0_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst || !rsp_valid)
            n_rsp_r <= 7'h00;
        else
            n_rsp_r <= n_rsp_r + 7'h01;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst || rsp_last)
            took_r <= 1'b0;
        else if (cmd_valid && cmd_ready)
            took_r <= 1'b1;
    end
    // first byte of each report, kept for the echo
    always_ff @(posedge core_clk) begin
        if (cmd_valid && cmd_ready && !took_r)
            cmd0_r <= cmd_data;
    end
    chk_resp_len: assert property (rsp_last |-> n_rsp_r == 7'h3f)
        else $error("response not 64 bytes");
    chk_resp_run: assert property ($rose(rsp_valid) |-> rsp_valid [*8])
        else $error("response bytes not back to back");
    chk_ready_busy: assert property (rsp_valid |-> !cmd_ready)
        else $error("ready during response");
    chk_echo_cmd: assert property ($rose(rsp_valid) |-> rsp_data == cmd0_r)
        else $error("command code not echoed");
    chk_ok_reply: assert property (nv_write_pulse |-> ##[1:3] ($rose(rsp_valid) ##1 rsp_data == 8'h00 ##1 rsp_data == 8'h20))
        else $error("commit without success reply");
    chk_lock_refuse: assert property (nv_write_pulse |-> nv_access_mode != psc_pkg::ACC_LOCK)
        else $error("commit while locked");
    chk_pass_refuse: assert property (nv_write_pulse |-> nv_access_mode != psc_pkg::ACC_PASS || password_matched)
        else $error("commit without password");
    chk_single_pulse: assert property (nv_write_pulse |=> !nv_write_pulse)
        else $error("commit pulse too long");
    chk_reset_copy: assert property ($fell(sys_rst) |-> ##3 work_designation == nv_designation)
        else $error("working copy not loaded");
    chk_ram_write: assert property (ram_wr_en |=> {work_remote_wake, work_int_mode, work_bus_hold} == $past(ram_wr_opt[4:0]))
        else $error("working options not written");
endmodule
bind psc_top psc_props u_props (.*);

//--- tb/psc_host.sv
// host model: streams one 64-byte command report into the decoder
module psc_host (
    input  wire logic         core_clk,
    input  wire logic         go,
    input  wire logic [511:0] rpt,
    input  wire logic         cmd_ready,
    output logic              cmd_valid,
    output logic [7:0]        cmd_data,
    output logic              cmd_last
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_data  = 8'h00;
        cmd_last  = 1'b0;
    end
    // each byte held until the edge that takes it
    always @(posedge go) begin
        for (int i = 0; i < 64; i++) begin
            #1;
            cmd_valid = 1'b1;
            cmd_data  = rpt[8*i +: 8];
            cmd_last  = (i == 63);
            do
                @(posedge core_clk);
            while (cmd_ready !== 1'b1);
        end
        #1;
        cmd_valid = 1'b0;
        cmd_last  = 1'b0;
        // released line must not show a stale byte
        cmd_data  = ~cmd_data;
    end
endmodule

//--- tb/tb.sv
// self-checking bench for the power-up settings command decoder
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] D1 = 64'h0201000201000201;
    localparam logic [63:0] D2 = 64'h0001020001020002;
    localparam logic [63:0] PW = 64'h3837363534333231;
    logic         core_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         go = 1'b0;
    logic         password_matched = 1'b0;
    logic         ram_wr_en = 1'b0;
    logic [17:0]  ram_wr_des = 18'h00000;
    logic [7:0]   ram_wr_val = 8'h00;
    logic [8:0]   ram_wr_dir = 9'h000;
    logic [7:0]   ram_wr_opt = 8'h00;
    logic [511:0] rpt = '0;
    logic         cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, nv_write_pulse;
    logic         work_remote_wake, work_bus_hold;
    logic [7:0]   cmd_data, rsp_data, nv_access_mode, work_out_level;
    logic [17:0]  nv_designation, work_designation;
    logic [63:0]  nv_password;
    logic [8:0]   work_direction;
    logic [2:0]   work_int_mode;
    logic [7:0]   rsp [64];
    int           n_mismatch = 0;
    int           num_checks = 0;
    int           cyc = 0;
    int           n_rsp;
    int           n_pulse;
    psc_top dut (.*);
    psc_host host (.core_clk(core_clk), .go(go), .rpt(rpt), .cmd_ready(cmd_ready),
                   .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_last(cmd_last));
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (5) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("work_dir", 9'h1ff, work_direction)
        `CHK("work_des", 18'h00000, work_designation)
    endtask
    task automatic do_cmd(input logic [7:0] sub, input logic [63:0] d, input logic [7:0] acc,
                          input logic [63:0] pw, input logic [7:0] st);
        rpt = '0;
        rpt[7:0] = psc_pkg::CMD_NVRAM;
        rpt[15:8] = sub;
        rpt[32 +: 64] = d;
        rpt[96 +: 8] = psc_pkg::DES_FUNC;
        // level, ignored byte, direction, ninth pin direction
        rpt[104 +: 32] = 32'h01c3ff5a;
        rpt[136 +: 8] = 8'hf5;
        rpt[144 +: 8] = acc;
        rpt[152 +: 64] = pw;
        n_rsp = 0;
        n_pulse = 0;
        @(posedge core_clk);
        #1 go = 1'b1;
        for (int i = 0; i < 400 && n_rsp < 64; i++) begin
            @(posedge core_clk);
            if (nv_write_pulse === 1'b1)
                n_pulse++;
            if (rsp_valid === 1'b1) begin
                rsp[n_rsp] = rsp_data;
                n_rsp++;
            end
        end
        #1 go = 1'b0;
        `CHK("rsp_count", 64, n_rsp)
        `CHK("rsp_cmd", psc_pkg::CMD_NVRAM, rsp[0])
        `CHK("rsp_status", st, rsp[1])
        `CHK("rsp_sub", (st == psc_pkg::ST_OK) ? psc_pkg::SUB_CHIP : 8'h00, rsp[2])
        `CHK("commit", (st == psc_pkg::ST_OK) ? 1 : 0, n_pulse)
    endtask
    task automatic chk_nv(input logic [63:0] d, input logic [7:0] acc, input logic [63:0] pw);
        logic [17:0] e;
        for (int i = 0; i < 8; i++)
            e[2*i +: 2] = d[8*i +: 2];
        // every written report puts the ninth pin on its function
        e[17:16] = (d != 64'h0) ? 2'h2 : 2'h0;
        `CHK("nv_des", e, nv_designation)
        `CHK("nv_acc", acc, nv_access_mode)
        `CHK("nv_pw", pw, nv_password)
    endtask
    task automatic t_open();
        do_cmd(psc_pkg::SUB_CHIP, D1, psc_pkg::ACC_OPEN, PW, psc_pkg::ST_OK);
        chk_nv(D1, psc_pkg::ACC_OPEN, PW);
        do_cmd(8'h10, D2, psc_pkg::ACC_OPEN, 64'h0, psc_pkg::ST_UNSUP);
        chk_nv(D1, psc_pkg::ACC_OPEN, PW);
    endtask
    task automatic t_protect();
        do_cmd(psc_pkg::SUB_CHIP, D2, psc_pkg::ACC_PASS, 64'h0, psc_pkg::ST_OK);
        chk_nv(D2, psc_pkg::ACC_PASS, PW);
        do_cmd(psc_pkg::SUB_CHIP, D1, psc_pkg::ACC_OPEN, 64'h0, psc_pkg::ST_BLOCK);
        chk_nv(D2, psc_pkg::ACC_PASS, PW);
        password_matched = 1'b1;
        do_cmd(psc_pkg::SUB_CHIP, D1, psc_pkg::ACC_LOCK, 64'h0, psc_pkg::ST_OK);
        chk_nv(D1, psc_pkg::ACC_LOCK, PW);
        do_cmd(psc_pkg::SUB_CHIP, D2, psc_pkg::ACC_OPEN, 64'h0, psc_pkg::ST_BLOCK);
        chk_nv(D1, psc_pkg::ACC_LOCK, PW);
    endtask
    // run while locked: working copy must stay writable
    task automatic t_ram();
        for (int m = 0; m < 5; m++) begin
            ram_wr_en = 1'b1;
            ram_wr_opt = {3'b000, m[0], m[2:0], m[1]};
            ram_wr_val = {m[3:0], ~m[3:0]};
            ram_wr_dir = {m[0], 8'h96};
            ram_wr_des = m[0] ? 18'h22496 : 18'h01249;
            @(posedge core_clk);
            #1 ram_wr_en = 1'b0;
            `CHK("wk_mode", m[2:0], work_int_mode)
            `CHK("wk_wake", m[0], work_remote_wake)
            `CHK("wk_hold", m[1], work_bus_hold)
            `CHK("wk_val", ram_wr_val, work_out_level)
            `CHK("wk_dir", ram_wr_dir, work_direction)
            `CHK("wk_des", ram_wr_des, work_designation)
            @(posedge core_clk);
            #1;
        end
    endtask
    initial begin
        do_reset();
        t_open();
        t_protect();
        t_ram();
        do_reset();
        chk_nv(64'h0, psc_pkg::ACC_OPEN, 64'h0);
        close_out();
    end
endmodule
